// file: src/dsd_decoder.sv
// Data-ALU opcode field decoder with an Avalon-MM control and status slave.
// Assumes the fetch stage and the bus master share clk; all inputs are synchronous.
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "dsd_cfg.svh"

module dsd_decoder (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Fetch stage
    input  wire logic            fetch_valid,
    input  wire logic [15:0]     fetch_word,
    output logic                 fetch_ready,
    // Decoded result
    output dsd_pkg::dsd_dec_t    dec,
    output dsd_pkg::dsd_ext_t    ext,
    // Avalon-MM slave
    input  wire logic [3:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    output logic [31:0]          avs_readdata,
    output logic                 avs_waitrequest
);

    typedef struct packed {
        logic                ready;
        logic [1:0]          words_left;
        dsd_pkg::dsd_dec_t   dec;
        dsd_pkg::dsd_ext_t   ext;
        logic [31:0]         ctrl;
        logic [15:0]         ill_cnt;
        logic [15:0]         last_word;
        logic                waitreq;
        logic [31:0]         rdata;
    } dsd_state_t;

    dsd_state_t state_reg;
    dsd_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Field decoders.

    function automatic dsd_pkg::dsd_reg_t dest_two(input logic [1:0] ff);
        unique case (ff)
            2'h0: dest_two = dsd_pkg::DSD_REG_DIN0;
            2'h1: dest_two = dsd_pkg::DSD_REG_DIN2;
            2'h3: dest_two = dsd_pkg::DSD_REG_DIN3;
            2'h2: dest_two = dsd_pkg::DSD_REG_NONE;
        endcase
    endfunction : dest_two

    // three-bit destination; codes 1, 3 and 7 reuse the two-bit table
    function automatic dsd_pkg::dsd_reg_t dest_three(input logic [2:0] fff);
        unique case (fff)
            3'h0:             dest_three = dsd_pkg::DSD_REG_ACC_A;
            3'h4:             dest_three = dsd_pkg::DSD_REG_ACC_B;
            3'h1, 3'h3, 3'h7: dest_three = dest_two(fff[2:1]);
            // reserved and unlisted codes select nothing
            default:          dest_three = dsd_pkg::DSD_REG_NONE;
        endcase
    endfunction : dest_three

    function automatic dsd_pkg::dsd_reg_t dest_narrow(input logic [2:0] f3);
        unique case (f3)
            3'h0:    dest_narrow = dsd_pkg::DSD_REG_ACC_A;
            3'h1:    dest_narrow = dsd_pkg::DSD_REG_ACC_B;
            3'h4:    dest_narrow = dsd_pkg::DSD_REG_DIN0;
            3'h6:    dest_narrow = dsd_pkg::DSD_REG_DIN2;
            3'h7:    dest_narrow = dsd_pkg::DSD_REG_DIN3;
            default: dest_narrow = dsd_pkg::DSD_REG_NONE;
        endcase
    endfunction : dest_narrow

    // one table in multiplier order; the short field is its lower half
    // Multiplier order puts the signed operand first; shifts swap it to value first.
    function automatic logic [5:0] src_pair(input logic [2:0] q);
        unique case (q)
            3'h1:    src_pair = {dsd_pkg::DSD_REG_DIN3, dsd_pkg::DSD_REG_ACC_B_HI};
            3'h2:    src_pair = {dsd_pkg::DSD_REG_DIN2, dsd_pkg::DSD_REG_DIN2};
            3'h3:    src_pair = {dsd_pkg::DSD_REG_DIN2, dsd_pkg::DSD_REG_ACC_A_HI};
            3'h4:    src_pair = {dsd_pkg::DSD_REG_DIN0, dsd_pkg::DSD_REG_DIN2};
            3'h5:    src_pair = {dsd_pkg::DSD_REG_DIN0, dsd_pkg::DSD_REG_DIN3};
            3'h7:    src_pair = {dsd_pkg::DSD_REG_DIN2, dsd_pkg::DSD_REG_DIN3};
            default: src_pair = {dsd_pkg::DSD_REG_NONE, dsd_pkg::DSD_REG_NONE};
        endcase
    endfunction : src_pair

    ////////////////////////////////////////////////////////////////////////////////
    // Word count of an entry, known from its first word alone.

    function automatic logic [1:0] entry_len(input logic [15:0] w);
        if (w[15:12] == 4'hE && w[7:6] == 2'h2 && w[2]) begin
            entry_len = `DSD_LEN_TWO;
        end else if (w[15:8] == 8'hE9 && w[7:6] == 2'h3 && w[4] == 1'b0
                     && w[3:2] == 2'h2) begin
            entry_len = `DSD_LEN_TWO;
        end else if (w[15:12] == 4'hA && w[7:5] == 3'h7) begin
            entry_len = `DSD_LEN_THREE;
        // variable class: operand bit 5 asks for an address word
        end else if (w[15:13] == 3'h2 && !w[10]) begin
            entry_len = w[5] ? `DSD_LEN_TWO : `DSD_LEN_ONE;
        end else begin
            entry_len = `DSD_LEN_ONE;
        end
    endfunction : entry_len

    ////////////////////////////////////////////////////////////////////////////////
    // Decode of one first word.

    function automatic dsd_pkg::dsd_dec_t decode(input logic [15:0] w);
        dsd_pkg::dsd_dec_t d;
        logic [2:0]        fff;
        logic [5:0]        pair;
        logic              is_shift;
        logic              q_bad;
        d          = '0;
        d.valid    = 1'b1;
        d.word     = w;
        d.len      = `DSD_LEN_ONE;
        d.cls      = dsd_pkg::DSD_CLS_OTHER;
        d.dest     = dsd_pkg::DSD_REG_NONE;
        d.comp_src = dsd_pkg::DSD_REG_NONE;
        d.src_first  = dsd_pkg::DSD_REG_NONE;
        d.src_second = dsd_pkg::DSD_REG_NONE;
        // destination bits 7, 1 and 0 form one field
        fff      = {w[7], w[1:0]};
        pair     = src_pair(w[6:4]);
        // Pair codes 000 and 110 name a register this core does not have.
        q_bad    = (w[6:4] == 3'h0) || (w[6:4] == 3'h6);
        is_shift = 1'b0;

        if (w == `DSD_ESCAPE_WORD) begin
            d.cls     = dsd_pkg::DSD_CLS_ESCAPE;
            d.illegal = 1'b1;
        // fixed bits matched, bit 8 left free in the first class
        end else if (w[15:13] == 3'h3 && w[10] && w[3:2] == 2'h2) begin
            d.cls    = dsd_pkg::DSD_CLS_THREE_OP;
            d.op_sel = {1'b0, w[12], w[11], w[9]};
            // codes 0, 1, 3, 4 and 7; the reserved and unlisted ones select nothing
            d.dest   = dest_three(fff);
        end else if (w[15:13] == 3'h3 && w[10] && w[3:2] == 2'h3) begin
            d.cls    = dsd_pkg::DSD_CLS_THREE_OP_TWO;
            // four select bits from 12, 11, 9 and 8
            d.op_sel = {w[12], w[11], w[9], w[8]};
            d.dest   = dest_three(fff);
            unique case (d.op_sel)
                `DSD_OP_SU_MUL, `DSD_OP_SU_MAC, `DSD_OP_INT_MUL: begin
                end
                `DSD_OP_ASR_VAR, `DSD_OP_ASL_VAR, `DSD_OP_LSR_VAR: begin
                    is_shift = 1'b1;
                end
                `DSD_OP_LSL_VAR: begin
                    is_shift = 1'b1;
                    if (fff[1:0] == 2'h0) begin
                        d.illegal = 1'b1;
                    end
                end
                `DSD_OP_ASR_ACC, `DSD_OP_LSR_ACC: begin
                    is_shift = 1'b1;
                    if (fff[1:0] != 2'h0) begin
                        d.illegal = 1'b1;
                    end
                end
                default: d.illegal = 1'b1;
            endcase
        end else if (w[15:13] == 3'h2 && w[10]) begin
            d.cls  = dsd_pkg::DSD_CLS_ADD_NARROW;
            d.dest = dest_narrow({w[12], w[9], w[8]});
            d.illegal = (d.dest == dsd_pkg::DSD_REG_NONE);
        end
        if (d.cls == dsd_pkg::DSD_CLS_THREE_OP || d.cls == dsd_pkg::DSD_CLS_THREE_OP_TWO) begin
            // shifts take the value first and the count second
            if (is_shift) begin
                d.src_first  = dsd_pkg::dsd_reg_t'(pair[2:0]);
                d.src_second = dsd_pkg::dsd_reg_t'(pair[5:3]);
                d.shift_cnt4 = 1'b1;
            end else begin
                d.src_first  = dsd_pkg::dsd_reg_t'(pair[5:3]);
                d.src_second = dsd_pkg::dsd_reg_t'(pair[2:0]);
            end
            // reserved destination or pair codes
            // Unlisted destination codes are refused too, so no stray register is picked.
            if (q_bad || d.dest == dsd_pkg::DSD_REG_NONE) begin
                d.illegal = 1'b1;
            end
        end

        d.comp_src = w[7] ? dsd_pkg::DSD_REG_ACC_A : dsd_pkg::DSD_REG_ACC_B;
        // word count from the first word
        d.len      = entry_len(w);
        // fixed-operation entries keep a zero operation select
        if (d.cls == dsd_pkg::DSD_CLS_OTHER) begin
            d.op_sel = 4'h0;
        end
        return d;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic take;
        logic ack;

        take       = fetch_valid && state_reg.ready;
        // A write lands only at the edge where the master sees waitrequest low.
        ack        = (avs_read || avs_write) && !state_reg.waitreq;
        state_next = state_reg;
        // Valid bits are pulses; the fields behind them hold until the next word of their kind.
        state_next.dec.valid = 1'b0;
        state_next.ext.valid = 1'b0;
        if (take && state_reg.words_left != 2'h0) begin
            state_next.ext.valid  = 1'b1;
            state_next.ext.word   = fetch_word;
            state_next.words_left = state_reg.words_left - 2'h1;
        end else if (take) begin
            state_next.dec        = decode(fetch_word);
            state_next.words_left = state_next.dec.len - 2'h1;
            state_next.last_word  = fetch_word;
            if (state_next.dec.illegal) begin
                state_next.ill_cnt = state_reg.ill_cnt + 16'h0001;
            end
        end

        // Clearing yields to a count arriving in the same cycle.
        if (ack && avs_write && avs_address == `DSD_OFF_CTRL) begin
            state_next.ctrl = {30'h0, 1'b0, avs_writedata[`DSD_CTRL_EN_BIT]};
            if (avs_writedata[`DSD_CTRL_CLR_BIT] && !(take && state_next.dec.illegal
                                                     && state_reg.words_left == 2'h0)) begin
                state_next.ill_cnt = 16'h0000;
            end
        end

        // Disabling lets a pending multiword instruction finish first.
        state_next.ready = state_next.ctrl[`DSD_CTRL_EN_BIT] || state_next.words_left != 2'h0;

        // Every access waits one cycle, so answers always come from flip-flops.
        state_next.waitreq = 1'b1;
        if ((avs_read || avs_write) && state_reg.waitreq) begin
            state_next.waitreq = 1'b0;
            unique case (avs_address)
                `DSD_OFF_CTRL:    state_next.rdata = state_reg.ctrl;
                `DSD_OFF_STATUS:  state_next.rdata = {26'h0, state_reg.words_left,
                                                      state_reg.dec.len, state_reg.dec.illegal,
                                                      state_reg.ready};
                `DSD_OFF_ILL_CNT: state_next.rdata = {16'h0, state_reg.ill_cnt};
                `DSD_OFF_LAST:    state_next.rdata = {16'h0, state_reg.last_word};
                default:          state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg         <= '0;
            state_reg.ctrl    <= `DSD_CTRL_RST;
            state_reg.ready   <= 1'b1;
            state_reg.waitreq <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    // Registering them costs a cycle of latency but keeps the fetch path short.

    assign fetch_ready     = state_reg.ready;
    assign dec             = state_reg.dec;
    assign ext             = state_reg.ext;
    assign avs_readdata    = state_reg.rdata;
    assign avs_waitrequest = state_reg.waitreq;

endmodule : dsd_decoder

// file: src/dsd_cfg.svh
// Constants of the data-ALU opcode field decoder: offsets, bit positions, codes.
// Assumes byte addresses on the register bus and 16-bit opcode words.
`ifndef DSD_CFG_SVH
`define DSD_CFG_SVH

`define DSD_WORD_W        16
`define DSD_OFF_CTRL      4'h0
`define DSD_OFF_STATUS    4'h4
`define DSD_OFF_ILL_CNT   4'h8
`define DSD_OFF_LAST      4'hC
`define DSD_CTRL_RST      32'h0000_0001
`define DSD_CTRL_EN_BIT   0
`define DSD_CTRL_CLR_BIT  1
`define DSD_ESCAPE_WORD   16'hE042
`define DSD_LEN_ONE       2'h1
`define DSD_LEN_TWO       2'h2
`define DSD_LEN_THREE     2'h3
`define DSD_OP_SU_MUL     4'h0
`define DSD_OP_SU_MAC     4'h1
`define DSD_OP_INT_MUL    4'h2
`define DSD_OP_ASR_VAR    4'h3
`define DSD_OP_ASL_VAR    4'h4
`define DSD_OP_LSR_VAR    4'h5
`define DSD_OP_LSL_VAR    4'h6
`define DSD_OP_ASR_ACC    4'h7
`define DSD_OP_LSR_ACC    4'h8
`define DSD_DEST_RSVD     3'h5
`define DSD_FFF_RSVD      3'h5

`endif

// file: src/dsd_pkg.sv
// Types shared by the opcode field decoder and its bench.
// Assumes nothing beyond a SystemVerilog elaborator.
package dsd_pkg;

    typedef enum logic [2:0] {
        DSD_REG_NONE,
        DSD_REG_ACC_A,
        DSD_REG_ACC_B,
        DSD_REG_ACC_A_HI,
        DSD_REG_ACC_B_HI,
        DSD_REG_DIN0,
        DSD_REG_DIN2,
        DSD_REG_DIN3
    } dsd_reg_t;

    typedef enum logic [2:0] {
        DSD_CLS_OTHER,
        DSD_CLS_THREE_OP,
        DSD_CLS_THREE_OP_TWO,
        DSD_CLS_ADD_NARROW,
        DSD_CLS_ESCAPE
    } dsd_cls_t;

    typedef struct packed {
        logic                valid;
        logic [15:0]         word;
        logic [1:0]          len;
        dsd_cls_t            cls;
        logic [3:0]          op_sel;
        dsd_reg_t            dest;
        dsd_reg_t            comp_src;
        dsd_reg_t            src_first;
        dsd_reg_t            src_second;
        logic                shift_cnt4;
        logic                illegal;
    } dsd_dec_t;

    typedef struct packed {
        logic                valid;
        logic [15:0]         word;
    } dsd_ext_t;

endpackage : dsd_pkg

// file: tb/dsd_decoder_properties.sv
// Port-level assertions for the opcode field decoder, bound into every instance.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module dsd_decoder_properties (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Fetch side
    input wire logic              fetch_valid,
    input wire logic              fetch_ready,
    // Decoded result
    input wire dsd_pkg::dsd_dec_t dec,
    input wire dsd_pkg::dsd_ext_t ext
);
    wire logic       take = fetch_valid && fetch_ready;
    wire logic [2:0] fff  = {dec.word[7], dec.word[1:0]};
    wire logic       cls2 = dec.word[15:13] == 3'h3 && dec.word[10] && dec.word[3:2] == 2'h3;
    wire logic       nar  = dec.word[15:13] == 3'h2 && dec.word[10];

    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    word_answer_a: assert property (take |=> dec.valid || ext.valid)
        else $error("Taken word gave no result.");
    no_phantom_a: assert property (!take |=> !dec.valid && !ext.valid)
        else $error("Result without a taken word.");
    two_word_a: assert property (dec.valid && dec.len == 2'h2 && take |=> ext.valid)
        else $error("Second word of a two-word entry is not an extension.");
    three_word_a: assert property (
        dec.valid && dec.len == 2'h3 && take ##1 take |=> ext.valid)
        else $error("Third word of a three-word entry is not an extension.");
    escape_stop_a: assert property (
        dec.valid && dec.word == 16'hE042 |-> dec.illegal && dec.cls == dsd_pkg::DSD_CLS_ESCAPE)
        else $error("Escape word not refused.");
    comp_acc_a: assert property (
        dec.valid |-> dec.comp_src == (dec.word[7] ? dsd_pkg::DSD_REG_ACC_A : dsd_pkg::DSD_REG_ACC_B))
        else $error("Complement source is not the other accumulator.");
    fff_rsvd_a: assert property (dec.valid && cls2 && fff == 3'h5 |-> dec.illegal)
        else $error("Reserved destination not flagged.");
    acc_sel_a: assert property (
        dec.valid && cls2 && fff[1:0] == 2'h0 && !dec.illegal
        |-> dec.dest == (fff[2] ? dsd_pkg::DSD_REG_ACC_B : dsd_pkg::DSD_REG_ACC_A))
        else $error("Accumulator select bit misread.");
    narrow_b_a: assert property (
        dec.valid && nar && {dec.word[12], dec.word[9:8]} == 3'h1
        |-> dec.dest == dsd_pkg::DSD_REG_ACC_B)
        else $error("Narrow destination code one not second accumulator.");
    comp_other_a: assert property (
        dec.valid && dec.cls inside {dsd_pkg::DSD_CLS_THREE_OP, dsd_pkg::DSD_CLS_THREE_OP_TWO}
        && dec.dest inside {dsd_pkg::DSD_REG_ACC_A, dsd_pkg::DSD_REG_ACC_B}
        |-> dec.comp_src != dec.dest)
        else $error("Complement source equals the destination.");
endmodule : dsd_decoder_properties

bind dsd_decoder dsd_decoder_properties u_props (.clk, .rst, .fetch_valid, .fetch_ready, .dec, .ext);

// file: tb/dsd_fetch_model.sv
// Fetch stage model that offers queued opcode words to the decoder.
// Assumes the bench fills its queue through push and paces it with slow.
`timescale 1ns/1ps
module dsd_fetch_model (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // Pacing from the bench
    input  wire logic   slow,
    // Word offer
    input  wire logic   fetch_ready,
    output logic        fetch_valid,
    output logic [15:0] fetch_word
);
    logic [15:0] q[$];
    logic        gap = 1'b0;

    task automatic push(input logic [15:0] w);
        q.push_back(w);
    endtask : push

    initial fetch_valid = 1'b0;
    initial fetch_word = 16'h0000;

    // words in order.
    // An idle word is inverted every cycle so that stale data never passes for an offer.
    always @(posedge clk) begin
        if (rst) begin
            fetch_valid <= 1'b0;
        end else if (!fetch_valid || fetch_ready) begin
            if (fetch_valid) begin
                void'(q.pop_front());
            end
            gap = slow && !gap;
            fetch_valid <= q.size() != 0 && !gap;
            fetch_word <= (q.size() != 0 && !gap) ? q[0] : ~fetch_word;
        end
    end
endmodule : dsd_fetch_model

// file: tb/dsd_decoder_tb.sv
// Self-checking bench: the fetch model feeds words, queued expectations judge each result.
// Assumes a 100 MHz clock and the register offsets of the decoder's control slave.
`timescale 1ns/1ps
module dsd_decoder_tb;
    typedef struct packed {
        logic [15:0]       w;
        logic [1:0]        n;
        logic              ill;
        dsd_pkg::dsd_reg_t dd;
        dsd_pkg::dsd_reg_t s1;
        dsd_pkg::dsd_reg_t s2;
    } dsd_exp_t;
    localparam dsd_pkg::dsd_reg_t NR = dsd_pkg::DSD_REG_NONE;
    localparam dsd_pkg::dsd_reg_t AR = dsd_pkg::DSD_REG_ACC_A;
    localparam dsd_pkg::dsd_reg_t BR = dsd_pkg::DSD_REG_ACC_B;
    localparam dsd_pkg::dsd_reg_t D0R = dsd_pkg::DSD_REG_DIN0;
    localparam dsd_pkg::dsd_reg_t D2R = dsd_pkg::DSD_REG_DIN2;
    localparam dsd_pkg::dsd_reg_t D3R = dsd_pkg::DSD_REG_DIN3;
    logic              clk = 1'b0, rst = 1'b1, slow = 1'b0, fetch_valid, fetch_ready;
    logic              avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0]        avs_address = 4'h0;
    logic [15:0]       fetch_word, lastw, xq[$];
    logic [31:0]       avs_writedata = 32'h0, avs_readdata, rd, r, seed = 32'h0000_0017;
    logic [2:0]        wf[6] = '{3'h0, 3'h4, 3'h1, 3'h3, 3'h7, 3'h5};
    logic [2:0]        nf[6] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h7, 3'h5};
    dsd_pkg::dsd_dec_t dec;
    dsd_pkg::dsd_ext_t ext;
    dsd_pkg::dsd_reg_t d;
    dsd_exp_t          e, exq[$];
    int                error_cnt, compares, ill_n;

    dsd_decoder dut (.clk, .rst, .fetch_valid, .fetch_word, .fetch_ready, .dec, .ext, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    dsd_fetch_model fm (.clk, .rst, .slow, .fetch_ready, .fetch_valid, .fetch_word);

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Top bit selects the narrow field; reserved and unlisted codes give no register.
    function automatic dsd_pkg::dsd_reg_t fff_reg(input logic [3:0] c);
        case (c)
            4'h0, 4'h8: return AR;
            4'h4, 4'h9: return BR;
            4'h1, 4'hC: return D0R;
            4'h3, 4'hE: return D2R;
            4'h7, 4'hF: return D3R;
            default: return NR;
        endcase
    endfunction : fff_reg

    function automatic logic [15:0] c2(input logic [3:0] op, input logic [2:0] f);
        return {3'h3, op[3:2], 1'b1, op[1:0], f[2], 3'h4, 2'h3, f[1:0]};
    endfunction : c2

    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : check

    task automatic send(input logic [15:0] w, input logic [1:0] n, input logic ill,
                        input dsd_pkg::dsd_reg_t dd, input dsd_pkg::dsd_reg_t s1,
                        input dsd_pkg::dsd_reg_t s2);
        logic [31:0] x;
        exq.push_back('{w, n, ill, dd, ill ? NR : s1, s2});
        fm.push(w);
        lastw = w;
        ill_n += ill;
        for (int i = 1; i < n; i++) begin
            x = rnd();
            xq.push_back(x[15:0]);
            fm.push(x[15:0]);
        end
    endtask : send

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic drain();
        while (fm.q.size() != 0 || fetch_valid !== 1'b0) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : drain

    task automatic print_verdict();
        $display("Compares %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        if (dec.valid === 1'b1) begin
            e = exq.pop_front();
            check(dec.word === e.w && dec.len === e.n, "length");
            check(dec.illegal === e.ill, "illegal flag");
            check(e.dd === NR || dec.dest === e.dd, "dest");
            check(e.s1 === NR || {dec.src_first,dec.src_second} === {e.s1, e.s2}, "src");
            check(dec.cls !== dsd_pkg::DSD_CLS_THREE_OP_TWO
                  || dec.op_sel === {dec.word[12:11], dec.word[9:8]}, "op select");
        end
        if (ext.valid === 1'b1) check(ext.word === xq.pop_front(), "extension");
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b1, 4'h0, 32'h0000_0003);
        send(16'hE042, 2'h1, 1'b1, NR, NR, NR);
        send(16'hE9C8, 2'h2, 1'b0, NR, NR, NR);
        send(16'hA0E0, 2'h3, 1'b0, NR, NR, NR);
        send(16'h4000, 2'h1, 1'b0, NR, NR, NR);
        send(16'h4020, 2'h2, 1'b0, NR, NR, NR);
        foreach (wf[i]) begin
            d = fff_reg({1'b0, wf[i]});
            send(c2(4'h0, wf[i]), 2'h1, d == NR, d, D0R, D2R);
            d = fff_reg({1'b1, nf[i]});
            send({3'h2, nf[i][2], 2'h1, nf[i][1:0], 8'h00}, 2'h1, d == NR, d, NR, NR);
        end
        send(c2(4'h3, 3'h0), 2'h1, 1'b0, AR, D2R, D0R);
        send(c2(4'h6, 3'h0), 2'h1, 1'b1, NR, NR, NR);
        send(c2(4'h6, 3'h1), 2'h1, 1'b0, D0R, D2R, D0R);
        send(16'h641C, 2'h1, 1'b0, AR, D3R, dsd_pkg::DSD_REG_ACC_B_HI);
        send(16'h677C, 2'h1, 1'b0, AR, D3R, D2R);
        send(16'h640C, 2'h1, 1'b1, AR, NR, NR);
        repeat (40) begin
            r = rnd();
            slow <= r[8];
            d = fff_reg({1'b0, wf[r[6:0] % 6]});
            send(c2(4'h0, wf[r[6:0] % 6]), 2'h1, d == NR, d, D0R, D2R);
            repeat (r[10:9]) @(posedge clk);
        end
        drain();
        bus(1'b0, 4'h8, 32'h0);
        check(rd[15:0] === ill_n[15:0], "illegal count");
        bus(1'b1, 4'h0, 32'h0000_0003);
        bus(1'b0, 4'h8, 32'h0);
        check(rd === 32'h0, "counter clear");
        bus(1'b0, 4'h0, 32'h0);
        check(rd === 32'h1, "control readback");
        bus(1'b0, 4'hC, 32'h0);
        check(rd[15:0] === lastw, "last first word");
        bus(1'b0, 4'h2, 32'h0);
        check(rd === 32'h0, "unmapped read");
        bus(1'b1, 4'h0, 32'h0);
        send(16'h4000, 2'h1, 1'b0, NR, NR, NR);
        repeat (6) @(posedge clk);
        check(fetch_ready === 1'b0 && exq.size() == 1, "taken while off");
        bus(1'b1, 4'h0, 32'h1);
        drain();
        check(exq.size() == 0 && xq.size() == 0, "missing results");
        bus(1'b0, 4'h4, 32'h0);
        check(rd === 32'h0000_0005, "status");
        print_verdict();
    end

    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule : dsd_decoder_tb
